// *** dsl_ctl_model.sv ***
`timescale 1ns/1ps
module dsl_ctl_model (
  // Clock
  input  wire logic clk,
  // Lines toward the drive
  output logic      strobe,
  output logic      valid
);
  initial begin
    strobe = 1'b0;
    valid  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Address check result settles a cycle before the load pulse
  task automatic load(input logic v, input int width);
    @(posedge clk);
    valid <= v;
    @(posedge clk);
    strobe <= 1'b1;
    repeat (width) @(posedge clk);
    strobe <= 1'b0;
    @(posedge clk);
    valid <= ~v;
  endtask
endmodule

// *** dsl_line_drivers.sv ***
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "dsl_params.svh"
// Operation
// - Seek accept pulse lasts one microsecond
// - Seek reply and notice outputs gated by selection and loaded heads
// - Valid address sets accept flip-flop at seek
// - Internal accept starts 500 ns after strobe
// - Rejected address gives latched bad-cylinder reply
// - Over-range address clears accept flip-flop
// - Internal bad-cylinder starts 450 ns after strobe
// - Notice output formed from bad, accept, ready
// - Notice driven only with option fitted
// - Access-ready needs four internal conditions
// - Access-ready line means ready, no seek
// - Access-ready blocked by write fault flag
// - Interrupt option drops selection qualifier
// - Seek-failed line gated like access-ready
// - Density line is selected and heads unloaded
module dsl_line_drivers (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Interrupt
  output logic             IRQ,
  // Cable and internal status inputs
  input  wire logic        ADDR_STROBE,
  input  wire logic        ADDR_VALID,
  input  wire logic        DRIVE_SELECTED,
  input  wire logic        HEADS_LOADED,
  input  wire logic        SEEK_FAILED_INTERNAL,
  input  wire logic        FILE_READY,
  input  wire logic        SEEK_FF_SET,
  input  wire logic        CARRIAGE_FF2_SET,
  input  wire logic        WRITE_FAULT,
  // Lines to the controller
  output logic             SEEK_ACCEPT_PULSE,
  output logic             BAD_CYLINDER_REPLY,
  output logic             ACCESS_OK_LINE,
  output logic             SEEK_FAILED_LINE,
  output logic             NOTICE_LINE,
  output logic             DENSITY_ID_LINE
);
  import dsl_pkg::*;

  localparam dsl_cnt_t ACK_LAST   = dsl_cnt_t'(`DSL_ACK_DELAY_CYC - 1);
  localparam dsl_cnt_t BAD_LAST   = dsl_cnt_t'(`DSL_BAD_DELAY_CYC - 1);
  localparam dsl_cnt_t PULSE_LAST = dsl_cnt_t'(`DSL_PULSE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Seek answer sequencer

  dsl_state_e state_r, state_nxt;
  dsl_cnt_t   cnt_r, cnt_nxt;
  logic       strobe_d_r, accept_ff_r, accept_ff_nxt;
  logic       bad_latch_r, bad_latch_nxt;
  logic       strobe_rise;
  logic       accept_int, bad_int;

  assign strobe_rise = ADDR_STROBE & ~strobe_d_r;
  assign accept_int  = (state_r == DSL_ACC);
  assign bad_int     = (state_r == DSL_BAD);

  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    accept_ff_nxt = accept_ff_r;
    bad_latch_nxt = bad_latch_r;
    // Strobes outside idle are ignored
    case (state_r)
      DSL_IDLE: begin
        if (strobe_rise) begin
          state_nxt     = DSL_WAIT;
          cnt_nxt       = '0;
          accept_ff_nxt = ADDR_VALID;
          bad_latch_nxt = 1'b0;
        end
      end
      DSL_WAIT: begin
        cnt_nxt = cnt_r + 6'h01;
        if (~accept_ff_r && cnt_r == BAD_LAST) begin
          state_nxt = DSL_BAD;
          cnt_nxt   = '0;
        end else if (accept_ff_r && cnt_r == ACK_LAST) begin
          state_nxt = DSL_ACC;
          cnt_nxt   = '0;
        end
      end
      DSL_ACC, DSL_BAD: begin
        cnt_nxt = cnt_r + 6'h01;
        if (state_r == DSL_BAD) begin
          bad_latch_nxt = 1'b1;
        end
        if (cnt_r == PULSE_LAST) begin
          state_nxt = DSL_IDLE;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = DSL_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r     <= DSL_IDLE;
      cnt_r       <= '0;
      strobe_d_r  <= 1'b0;
      accept_ff_r <= 1'b0;
      bad_latch_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      strobe_d_r  <= ADDR_STROBE;
      accept_ff_r <= accept_ff_nxt;
      bad_latch_r <= bad_latch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line drivers

  logic [2:0] ctrl_r, ctrl_nxt;
  logic       gate, ready_gate, access_ok_int, notice_raw;
  logic       accept_line_nxt, bad_line_nxt, ok_line_nxt, fail_line_nxt;
  logic       notice_line_nxt, density_nxt;

  assign gate          = DRIVE_SELECTED & HEADS_LOADED;
  assign access_ok_int = ~SEEK_FAILED_INTERNAL & FILE_READY
                         & ~SEEK_FF_SET & ~CARRIAGE_FF2_SET;
  assign notice_raw    = ~accept_int & (bad_int | ~access_ok_int);

  always_comb begin
    ready_gate      = ctrl_r[`DSL_CTRL_INTCOMP_BIT] ? 1'b1 : gate;
    accept_line_nxt = gate & accept_int;
    bad_line_nxt    = gate & bad_latch_r;
    ok_line_nxt     = ready_gate & access_ok_int & ~WRITE_FAULT;
    fail_line_nxt   = ready_gate & SEEK_FAILED_INTERNAL;
    notice_line_nxt = ctrl_r[`DSL_CTRL_NOTICE_BIT] & gate
                      & notice_raw;
    density_nxt     = ctrl_r[`DSL_CTRL_DENSITY_BIT] & DRIVE_SELECTED
                      & ~HEADS_LOADED;
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      SEEK_ACCEPT_PULSE  <= 1'b0;
      BAD_CYLINDER_REPLY <= 1'b0;
      ACCESS_OK_LINE     <= 1'b0;
      SEEK_FAILED_LINE   <= 1'b0;
      NOTICE_LINE        <= 1'b0;
      DENSITY_ID_LINE    <= 1'b0;
    end else begin
      SEEK_ACCEPT_PULSE  <= accept_line_nxt;
      BAD_CYLINDER_REPLY <= bad_line_nxt;
      ACCESS_OK_LINE     <= ok_line_nxt;
      SEEK_FAILED_LINE   <= fail_line_nxt;
      NOTICE_LINE        <= notice_line_nxt;
      DENSITY_ID_LINE    <= density_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave and interrupts

  logic [`DSL_EV_WIDTH-1:0] istat_r, istat_nxt, imask_r, imask_nxt, events;
  logic [31:0]              rdata_nxt;
  logic                     wait_nxt, irq_nxt, fail_d_r, take_wr;

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
    hit = (adr == ofs);
  endfunction

  assign take_wr = AVS_WRITE & ~AVS_WAITREQUEST;
  assign events  = {SEEK_FAILED_INTERNAL & ~fail_d_r,
                    state_nxt == DSL_BAD && state_r != DSL_BAD,
                    state_nxt == DSL_ACC && state_r != DSL_ACC};

  always_comb begin
    wait_nxt  = ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    ctrl_nxt  = ctrl_r;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    rdata_nxt = AVS_READDATA;
    if (take_wr && hit(AVS_ADDRESS, `DSL_OFS_CTRL)) begin
      ctrl_nxt = AVS_WRITEDATA[2:0];
    end
    if (take_wr && hit(AVS_ADDRESS, `DSL_OFS_IRQ_MASK)) begin
      imask_nxt = AVS_WRITEDATA[`DSL_EV_WIDTH-1:0];
    end
    if (take_wr && hit(AVS_ADDRESS, `DSL_OFS_IRQ_STAT)) begin
      istat_nxt = istat_r & ~AVS_WRITEDATA[`DSL_EV_WIDTH-1:0];
    end
    // Set wins over a same-cycle clear
    istat_nxt = istat_nxt | events;
    irq_nxt   = |(istat_nxt & imask_nxt);
    if (AVS_READ && AVS_WAITREQUEST) begin
      rdata_nxt = 32'h0000_0000;
      if (hit(AVS_ADDRESS, `DSL_OFS_CTRL)) begin
        rdata_nxt[2:0] = ctrl_r;
      end
      if (hit(AVS_ADDRESS, `DSL_OFS_STATUS)) begin
        rdata_nxt[6:0] = {access_ok_int, bad_latch_r, accept_ff_r,
                          bad_int, accept_int, state_r};
      end
      if (hit(AVS_ADDRESS, `DSL_OFS_IRQ_STAT)) begin
        rdata_nxt[`DSL_EV_WIDTH-1:0] = istat_r;
      end
      if (hit(AVS_ADDRESS, `DSL_OFS_IRQ_MASK)) begin
        rdata_nxt[`DSL_EV_WIDTH-1:0] = imask_r;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r          <= `DSL_CTRL_RESET;
      imask_r         <= '0;
      istat_r         <= '0;
      fail_d_r        <= 1'b0;
      AVS_READDATA    <= 32'h0000_0000;
      AVS_WAITREQUEST <= 1'b1;
      IRQ             <= 1'b0;
    end else begin
      ctrl_r          <= ctrl_nxt;
      imask_r         <= imask_nxt;
      istat_r         <= istat_nxt;
      fail_d_r        <= SEEK_FAILED_INTERNAL;
      AVS_READDATA    <= rdata_nxt;
      AVS_WAITREQUEST <= wait_nxt;
      IRQ             <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  a_accept_pulse_width: assert property (
    $rose(accept_int) |-> accept_int [*8] ##32 accept_int ##1 !accept_int)
    else $error("internal accept pulse not one microsecond");

  a_accept_gated_out: assert property (
    SEEK_ACCEPT_PULSE |-> $past(gate) && $past(accept_int))
    else $error("accept line driven without selection or accept");

  a_accept_ff_load: assert property (
    (state_r == DSL_IDLE && strobe_rise) |=> accept_ff_r == $past(ADDR_VALID))
    else $error("accept flip-flop did not take address check");

  a_accept_delay: assert property (
    (state_r == DSL_IDLE && strobe_rise && ADDR_VALID)
      |-> ##21 accept_int && !$past(accept_int))
    else $error("accept not started 500 ns after strobe");

  a_bad_latch_held: assert property (
    (bad_int && gate) |=> ##1 BAD_CYLINDER_REPLY)
    else $error("bad cylinder reply missing");

  a_bad_no_accept: assert property (
    (state_r == DSL_IDLE && strobe_rise && !ADDR_VALID)
      |-> ##21 !accept_int && !accept_ff_r)
    else $error("rejected address produced accept");

  a_bad_delay: assert property (
    (state_r == DSL_IDLE && strobe_rise && !ADDR_VALID)
      |-> ##19 bad_int && !$past(bad_int))
    else $error("bad cylinder not started 450 ns after strobe");

  a_notice_option: assert property (
    !ctrl_r[`DSL_CTRL_NOTICE_BIT] |=> !NOTICE_LINE)
    else $error("notice driven without option");

  a_ready_block: assert property (
    (WRITE_FAULT || !access_ok_int) |=> !ACCESS_OK_LINE)
    else $error("access ready despite fault or not ready");

  a_ready_unsel: assert property (
    (!ctrl_r[`DSL_CTRL_INTCOMP_BIT] && !DRIVE_SELECTED)
      |=> !ACCESS_OK_LINE && !SEEK_FAILED_LINE)
    else $error("ready or fail line driven while unselected");

  a_density_line: assert property (
    ##1 DENSITY_ID_LINE == $past(ctrl_r[`DSL_CTRL_DENSITY_BIT]
                                 && DRIVE_SELECTED && !HEADS_LOADED))
    else $error("density line wrong");

  // Line gating and status forms
  a_lines_ungated: assert property (
    !gate |=> !SEEK_ACCEPT_PULSE && !BAD_CYLINDER_REPLY && !NOTICE_LINE)
    else $error("answer or notice line driven while not gated");

  a_bad_reply_out: assert property (
    (gate && bad_latch_r) |=> BAD_CYLINDER_REPLY)
    else $error("latched bad cylinder not shown on reply line");

  a_bad_latch_set: assert property (
    bad_int |=> bad_latch_r)
    else $error("bad cylinder latch not set");

  a_bad_latch_clear: assert property (
    (state_r == DSL_IDLE && strobe_rise) |=> !bad_latch_r)
    else $error("bad cylinder latch not cleared by new strobe");

  a_bad_pulse_width: assert property (
    $rose(bad_int) |-> bad_int [*8] ##32 bad_int ##1 !bad_int)
    else $error("internal bad cylinder pulse not forty cycles");

  a_busy_ignores: assert property (
    (state_r != DSL_IDLE) |=> accept_ff_r == $past(accept_ff_r))
    else $error("accept flip-flop changed during an answer");

  a_notice_on_bad: assert property (
    (ctrl_r[`DSL_CTRL_NOTICE_BIT] && gate && bad_int) |=> NOTICE_LINE)
    else $error("notice missing during bad cylinder");

  a_notice_accept: assert property (
    accept_int |=> !NOTICE_LINE)
    else $error("notice driven during accept");

  a_ready_line_on: assert property (
    (gate && FILE_READY && !SEEK_FAILED_INTERNAL && !SEEK_FF_SET
      && !CARRIAGE_FF2_SET && !WRITE_FAULT) |=> ACCESS_OK_LINE)
    else $error("access ready missing with all conditions met");

  a_ready_needs_four: assert property (
    (SEEK_FAILED_INTERNAL || !FILE_READY || SEEK_FF_SET || CARRIAGE_FF2_SET)
      |=> !ACCESS_OK_LINE)
    else $error("access ready with a condition missing");

  a_intcomp_ready: assert property (
    (ctrl_r[`DSL_CTRL_INTCOMP_BIT] && access_ok_int && !WRITE_FAULT)
      |=> ACCESS_OK_LINE)
    else $error("interrupt option did not free access ready");

  a_fail_line_on: assert property (
    (gate && SEEK_FAILED_INTERNAL) |=> SEEK_FAILED_LINE)
    else $error("seek failed line missing");

  a_fail_line_off: assert property (
    !SEEK_FAILED_INTERNAL |=> !SEEK_FAILED_LINE)
    else $error("seek failed line without failure");

  // Bus and interrupts
  a_wait_single: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");

  a_irq_level: assert property (
    IRQ == |(istat_r & imask_r))
    else $error("interrupt output does not follow masked status");

  a_istat_set_wins: assert property (
    (events != '0) |=> (istat_r & $past(events)) == $past(events))
    else $error("interrupt event lost");

  c_accept_seen: cover property (gate ##1 SEEK_ACCEPT_PULSE);
  c_notice_seen: cover property ($rose(NOTICE_LINE));
  c_bad_seen:    cover property (gate && bad_int ##2 BAD_CYLINDER_REPLY);
  c_irq_seen:    cover property ($rose(IRQ));
  c_ready_intc:  cover property (ctrl_r[`DSL_CTRL_INTCOMP_BIT] && !DRIVE_SELECTED
                                 ##1 ACCESS_OK_LINE);

endmodule

// *** dsl_params.svh ***
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH

// Clock and timing
`define DSL_CLK_PERIOD_PS   25000
`define DSL_ACK_DELAY_NS    500
`define DSL_BAD_DELAY_NS    450
`define DSL_PULSE_US        1
`define DSL_ACK_DELAY_CYC   ((`DSL_ACK_DELAY_NS * 1000 + `DSL_CLK_PERIOD_PS - 1) / `DSL_CLK_PERIOD_PS)
`define DSL_BAD_DELAY_CYC   ((`DSL_BAD_DELAY_NS * 1000 + `DSL_CLK_PERIOD_PS - 1) / `DSL_CLK_PERIOD_PS)
`define DSL_PULSE_CYC       ((`DSL_PULSE_US * 1000000 + `DSL_CLK_PERIOD_PS - 1) / `DSL_CLK_PERIOD_PS)

// Register byte offsets
`define DSL_OFS_CTRL        4'h0
`define DSL_OFS_STATUS      4'h4
`define DSL_OFS_IRQ_STAT    4'h8
`define DSL_OFS_IRQ_MASK    4'hC

// Control fields
`define DSL_CTRL_NOTICE_BIT  0
`define DSL_CTRL_INTCOMP_BIT 1
`define DSL_CTRL_DENSITY_BIT 2
`define DSL_CTRL_RESET       3'h0

// Interrupt event fields
`define DSL_EV_ACCEPT_BIT   0
`define DSL_EV_BAD_BIT      1
`define DSL_EV_FAIL_BIT     2
`define DSL_EV_WIDTH        3

`endif

// *** dsl_pkg.sv ***
package dsl_pkg;

  typedef enum logic [1:0] {
    DSL_IDLE = 2'b00,
    DSL_WAIT = 2'b01,
    DSL_ACC  = 2'b10,
    DSL_BAD  = 2'b11
  } dsl_state_e;

  typedef logic [5:0] dsl_cnt_t;

endpackage

// *** dsl_testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic        mclk, rstn, avs_read, avs_write, irq, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        addr_strobe, addr_valid, sel, heads, sfi, fready, seek_ff, carr_ff2;
  logic        wfault, acc_p, bad_r, ok_l, sf_l, note_l, dens_l;
  int          err_total, checks_done, ta, wa, tbad;

  dsl_line_drivers dut_u (
    .MCLK(mclk), .RSTN(rstn), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .ADDR_STROBE(addr_strobe),
    .ADDR_VALID(addr_valid), .DRIVE_SELECTED(sel), .HEADS_LOADED(heads),
    .SEEK_FAILED_INTERNAL(sfi), .FILE_READY(fready), .SEEK_FF_SET(seek_ff),
    .CARRIAGE_FF2_SET(carr_ff2), .WRITE_FAULT(wfault), .SEEK_ACCEPT_PULSE(acc_p),
    .BAD_CYLINDER_REPLY(bad_r), .ACCESS_OK_LINE(ok_l), .SEEK_FAILED_LINE(sf_l),
    .NOTICE_LINE(note_l), .DENSITY_ID_LINE(dens_l));

  dsl_ctl_model ctl_u (.clk(mclk), .strobe(addr_strobe), .valid(addr_valid));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Avalon cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) err_total++;
  endtask

  task automatic put(input logic s, h, f, r, k, c, w);
    @(posedge mclk);
    sel      <= s;
    heads    <= h;
    sfi      <= f;
    fready   <= r;
    seek_ff  <= k;
    carr_ff2 <= c;
    wfault   <= w;
  endtask

  task automatic lines(input logic [3:0] exp);
    repeat (2) @(posedge mclk);
    #1;
    cmp({ok_l, sf_l, note_l, dens_l}, exp);
  endtask

  // Cycle numbers count the strobe-rise edge as zero
  task automatic seek(input logic v);
    int n;
    ta = -1;
    wa = 0;
    tbad = -1;
    fork
      ctl_u.load(v, 3);
    join_none
    repeat (2) @(posedge mclk);
    for (n = 0; n < 80; n++) begin
      @(posedge mclk);
      #1;
      if (acc_p === 1'b1) begin
        if (ta < 0) ta = n;
        wa++;
      end
      if (bad_r === 1'b1 && tbad < 0) tbad = n;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(0, 4'h0, 32'h0);
    cmp(rd, 32'h0);
    bus(0, 4'hC, 32'h0);
    cmp(rd, 32'h0);
    bus(1, 4'h2, 32'hF);
    bus(0, 4'h2, 32'h0);
    cmp(rd, 32'h0);
    bus(1, 4'h0, 32'h7);
    bus(0, 4'h0, 32'h0);
    cmp(rd, 32'h7);
    bus(1, 4'h0, 32'h0);
  endtask

  task automatic t_accept();
    put(1, 1, 0, 1, 0, 0, 0);
    seek(1'b1);
    cmp(ta, 21);
    cmp(wa, 40);
    cmp(tbad, -1);
    bus(0, 4'h4, 32'h0);
    cmp(rd, 32'h50);
    bus(0, 4'h8, 32'h0);
    cmp(rd, 32'h1);
    bus(1, 4'hC, 32'h1);
    lines(4'b1000);
    cmp(irq, 1'b1);
    bus(1, 4'h8, 32'h1);
    lines(4'b1000);
    cmp(irq, 1'b0);
  endtask

  task automatic t_bad();
    seek(1'b0);
    cmp(tbad, 20);
    cmp(ta, -1);
    cmp(bad_r, 1'b1);
    bus(0, 4'h4, 32'h0);
    cmp(rd, 32'h60);
    bus(0, 4'h8, 32'h0);
    cmp(rd, 32'h2);
    seek(1'b1);
    cmp(ta, 21);
    cmp(bad_r, 1'b0);
  endtask

  task automatic t_gate();
    put(0, 1, 0, 1, 0, 0, 0);
    seek(1'b1);
    cmp(ta, -1);
    seek(1'b0);
    cmp(tbad, -1);
  endtask

  task automatic t_lines();
    put(1, 1, 0, 1, 0, 0, 0);
    lines(4'b1000);
    put(1, 1, 0, 1, 0, 0, 1);
    lines(4'b0000);
    put(1, 1, 0, 1, 1, 0, 0);
    lines(4'b0000);
    put(1, 1, 0, 1, 0, 1, 0);
    lines(4'b0000);
    put(1, 1, 0, 0, 0, 0, 0);
    lines(4'b0000);
    put(1, 1, 1, 1, 0, 0, 0);
    lines(4'b0100);
    bus(0, 4'h8, 32'h0);
    cmp(rd, 32'h7);
    put(0, 1, 1, 1, 0, 0, 0);
    lines(4'b0000);
    bus(1, 4'h0, 32'h2);
    lines(4'b0100);
    put(0, 1, 0, 1, 0, 0, 0);
    lines(4'b1000);
    bus(1, 4'h0, 32'h5);
    put(1, 1, 0, 0, 0, 0, 0);
    lines(4'b0010);
    put(1, 1, 0, 1, 0, 0, 0);
    lines(4'b1000);
    put(1, 0, 0, 1, 0, 0, 0);
    lines(4'b0001);
    bus(1, 4'h0, 32'h0);
    lines(4'b0000);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checks_done = 0;
    rstn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {sel, heads, sfi, fready, seek_ff, carr_ff2, wfault} = '0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_accept();
    t_bad();
    t_gate();
    t_lines();
    report_and_stop();
  end

  initial begin
    #(20000 * 25);
    err_total++;
    report_and_stop();
  end
endmodule
